// *** rt_log_map.svh ***
`ifndef RT_LOG_MAP_SVH
`define RT_LOG_MAP_SVH
`define REG_CFG 5'h01
`define REG_MASK1 5'h02
`define REG_MASK2 5'h03
`define REG_STAT1 5'h04
`define REG_STAT2 5'h05
`define REG_CFG6 5'h06
`define REG_TTAG 5'h07
`define REG_STACK 5'h08
`define REG_QPTR 5'h1f
`define CFG_RES_LO 0
`define CFG_CLR_SYNC 3
`define CFG_LOAD_SYNC 4
`define CFG_LSB_FILT 5
`define CFG_MODE_DATA 6
`define CFG6_NO_VALID 7
`define CFG6_NO_INVALID 8
`define RES_EXT 3'h7
`define RES_MAX 3'h5
`define TICK_US 1
`define CLK_MHZ 200
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define STACK_HALF_BIT 7
`define QUEUE_BITS 6
`endif

// *** rt_log_pkg.sv ***
package rt_log_pkg;
   typedef struct packed {
      logic [15:0] cmd;
      logic [15:0] data_ptr;
      logic [15:0] mode_data;
      logic mode_code;
      logic chan_b;
      logic illegal;
      logic [4:0] err;
      logic sync_nodata;
      logic sync_data;
      logic sa_sel;
      logic mc_sel;
      logic tx_timeout;
      logic cbuf_full;
      logic cbuf_half;
      logic mt_cmd_half;
      logic mt_data_half;
   } msg_info_t;
   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [15:0] data;
   } ram_wr_t;
   typedef enum logic [2:0] {S_IDLE = 3'h0, S_D0 = 3'h1, S_D1 = 3'h3, S_D2 = 3'h2,
      S_D3 = 3'h6, S_Q0 = 3'h7, S_Q1 = 3'h5} eng_state_t;
endpackage

// *** rt_message_log_and_interrupt_queue.sv ***
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`include "rt_log_map.svh"
module rt_message_log_and_interrupt_queue
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic msg_start_i,
   input wire logic msg_done_i,
   input wire rt_log_pkg::msg_info_t msg_i,
   input wire logic tag_clk_i,
   input wire logic rtaddr_par_err_i,
   input wire logic ram_par_err_i,
   input wire logic [15:0] ram_par_addr_i,
   input wire logic bit_done_i,
   output rt_log_pkg::ram_wr_t ram_o,
   output logic irq_o
);
   import rt_log_pkg::*;

   eng_state_t state;
   msg_info_t cur;
   logic [15:0] cfg, cfg6, mask1, mask2, stat1, stat2, ttag, stk, qptr;
   logic [15:0] qvec, qpar, nm_pend, ram_par_addr;
   logic qmsg;
   logic [7:0] pre_cnt;
   logic [6:0] div_cnt;
   logic tag_q, tag_rise, us_tick, tt_inc, tt_set, tt_clr, tt_load, tt_roll;
   logic [2:0] res;
   logic wb_req, wr_en;
   logic [31:0] wdat;
   logic [15:0] next_stk, mev, nev, mvec, bsw;
   logic half_stk, full_stk, invalid, q_allow, q_wrap;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_en = wb_req && wb_we_i;
   assign wdat = {wb_sel_i[3] ? wb_dat_i[31:24] : 8'h00, wb_sel_i[2] ? wb_dat_i[23:16] : 8'h00,
      wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
   assign res = cfg[`CFG_RES_LO +: 3];

   // Bus slave answers every access one cycle after the request, unmapped reads as zero.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0;
         if (wb_req && !wb_we_i)
         begin
            unique case (wb_adr_i[6:2])
               `REG_CFG: wb_dat_o <= {16'h0, cfg};
               `REG_MASK1: wb_dat_o <= {16'h0, mask1};
               `REG_MASK2: wb_dat_o <= {16'h0, mask2};
               `REG_STAT1: wb_dat_o <= {16'h0, stat1};
               `REG_STAT2: wb_dat_o <= {16'h0, stat2};
               `REG_CFG6: wb_dat_o <= {16'h0, cfg6};
               `REG_TTAG: wb_dat_o <= {16'h0, ttag};
               `REG_STACK: wb_dat_o <= {16'h0, stk};
               `REG_QPTR: wb_dat_o <= {16'h0, qptr};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // Plain control registers written by software.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg <= 16'h0;
         cfg6 <= 16'h0;
         mask1 <= 16'h0;
         mask2 <= 16'h0;
      end
      else if (wr_en)
      begin
         unique case (wb_adr_i[6:2])
            `REG_CFG: cfg <= wdat[15:0];
            `REG_CFG6: cfg6 <= wdat[15:0];
            `REG_MASK1: mask1 <= wdat[15:0];
            `REG_MASK2: mask2 <= wdat[15:0];
            default: ;
         endcase
      end
   end

   // Time base: one microsecond tick, then a power of two divider.
   assign us_tick = pre_cnt == 8'(`TICK_CYCLES - 1);
   assign tag_rise = tag_clk_i && !tag_q;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pre_cnt <= 8'h0;
         div_cnt <= 7'h0;
         tag_q <= 1'b0;
      end
      else
      begin
         tag_q <= tag_clk_i;
         // A tag write restarts the time base, so the first count is a full period.
         if (tt_set)
         begin
            pre_cnt <= 8'h0;
            div_cnt <= 7'h0;
         end
         else
         begin
            pre_cnt <= us_tick ? 8'h0 : pre_cnt + 8'h1;
            if (us_tick)
               div_cnt <= tt_inc ? 7'h0 : div_cnt + 7'h1;
         end
      end
   end
   // A count left over from a slower resolution ends at the next tick.
   assign tt_inc = (res == `RES_EXT) ? tag_rise :
      (res <= `RES_MAX && us_tick && div_cnt >= 7'((7'h2 << res) - 7'h1));
   assign tt_set = wr_en && wb_adr_i[6:2] == `REG_TTAG;
   assign tt_clr = msg_done_i && state == S_IDLE && msg_i.sync_nodata && cfg[`CFG_CLR_SYNC];
   assign tt_load = msg_done_i && state == S_IDLE && msg_i.sync_data && cfg[`CFG_LOAD_SYNC]
      && !(cfg[`CFG_LSB_FILT] && msg_i.mode_data[0]);
   assign tt_roll = tt_inc && !tt_set && !tt_clr && !tt_load && ttag == 16'hffff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ttag <= 16'h0;
      else if (tt_set)
         ttag <= wdat[15:0];
      else if (tt_clr)
         ttag <= 16'h0;
      else if (tt_load)
         ttag <= msg_i.mode_data;
      else if (tt_inc)
         ttag <= ttag + 16'h1;
   end

   // Descriptor stack pointer advances by one descriptor per message.
   assign next_stk = stk + 16'h4;
   assign half_stk = next_stk[`STACK_HALF_BIT] && !stk[`STACK_HALF_BIT];
   assign full_stk = next_stk[7:0] < stk[7:0];
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         stk <= 16'h0;
      else if (state == S_D3)
         stk <= next_stk;
      else if (wr_en && wb_adr_i[6:2] == `REG_STACK)
         stk <= wdat[15:0];
   end

   // Message events: eom, error, subaddr, buffer full/half, stack full/half, mode code,
   // timeout, illegal, monitor command half, monitor data half.
   assign invalid = cur.illegal || (|cur.err);
   assign mev = {4'h0, cur.mt_data_half, cur.mt_cmd_half, cur.illegal, cur.tx_timeout,
      cur.mc_sel, half_stk, full_stk, cur.cbuf_half, cur.cbuf_full, cur.sa_sel, invalid,
      1'b1};
   assign mvec = mev & mask1;
   assign q_allow = invalid ? !cfg6[`CFG6_NO_INVALID] : !cfg6[`CFG6_NO_VALID];
   // Non-message events: tag rollover, address parity, RAM parity, self-test done.
   assign nev = {12'h0, bit_done_i, ram_par_err_i, rtaddr_par_err_i, tt_roll};
   assign q_wrap = (state == S_Q0 || state == S_Q1) && qptr[5:0] == 6'h3f;

   assign bsw = {1'b1, 1'b0, cur.chan_b, cur.illegal, 7'h0, cur.err};

   // Sticky status, set wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stat1 <= 16'h0;
         stat2 <= 16'h0;
      end
      else
      begin
         stat1 <= (stat1 & ~((wr_en && wb_adr_i[6:2] == `REG_STAT1) ? wdat[15:0] : 16'h0))
            | ((state == S_D3) ? mev : 16'h0);
         stat2 <= (stat2 & ~((wr_en && wb_adr_i[6:2] == `REG_STAT2) ? wdat[15:0] : 16'h0))
            | nev | {11'h0, q_wrap, 4'h0};
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |({stat1 & mask1, stat2 & mask2});
   end

   // Pending non-message entries waiting for the write engine.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         nm_pend <= 16'h0;
         ram_par_addr <= 16'h0;
      end
      else
      begin
         if (ram_par_err_i)
            ram_par_addr <= ram_par_addr_i;
         if (state == S_IDLE && !msg_done_i && !msg_start_i && nm_pend != 16'h0)
            nm_pend <= nev & mask2;
         else
            nm_pend <= nm_pend | (nev & mask2);
      end
   end

   // Queue pointer: host sets it, each queue word moves it on modulo 64.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         qptr <= 16'h0;
      else if (state == S_Q0 || state == S_Q1)
         qptr <= {qptr[15:`QUEUE_BITS], qptr[5:0] + 6'h1};
      else if (wr_en && wb_adr_i[6:2] == `REG_QPTR)
         qptr <= wdat[15:0];
   end

   // Write engine for descriptors and queue entries into shared RAM.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state <= S_IDLE;
         cur <= '0;
         ram_o <= '0;
         qvec <= 16'h0;
         qpar <= 16'h0;
         qmsg <= 1'b0;
      end
      else
      begin
         ram_o.we <= 1'b0;
         unique case (state)
            S_IDLE:
            begin
               if (msg_done_i)
               begin
                  cur <= msg_i;
                  state <= S_D0;
               end
               else if (msg_start_i)
               begin
                  ram_o <= '{we: 1'b1, addr: stk, data: {1'b0, 1'b1, msg_i.chan_b, 13'h0}};
               end
               else if (nm_pend != 16'h0)
               begin
                  qvec <= {nm_pend[14:0], 1'b0};
                  qpar <= nm_pend[2] ? ram_par_addr : 16'h0000;
                  qmsg <= 1'b0;
                  state <= S_Q0;
               end
            end
            S_D0:
            begin
               ram_o <= '{we: 1'b1, addr: stk, data: bsw};
               state <= S_D1;
            end
            S_D1:
            begin
               ram_o <= '{we: 1'b1, addr: stk + 16'h1, data: ttag};
               state <= S_D2;
            end
            S_D2:
            begin
               ram_o <= '{we: 1'b1, addr: stk + 16'h2,
                  data: (cur.mode_code && cfg[`CFG_MODE_DATA]) ? cur.mode_data : cur.data_ptr};
               state <= S_D3;
            end
            S_D3:
            begin
               ram_o <= '{we: 1'b1, addr: stk + 16'h3, data: cur.cmd};
               qvec <= {mvec[14:0], 1'b1};
               qpar <= stk;
               qmsg <= 1'b1;
               state <= (mvec != 16'h0 && q_allow) ? S_Q0 : S_IDLE;
            end
            S_Q0:
            begin
               ram_o <= '{we: 1'b1, addr: {qptr[15:`QUEUE_BITS], qptr[5:0]}, data: qvec};
               state <= S_Q1;
            end
            S_Q1:
            begin
               ram_o <= '{we: 1'b1, addr: {qptr[15:`QUEUE_BITS], qptr[5:0]}, data: qpar};
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   sequence desc_walk;
      state == S_D1 ##1 state == S_D2 ##1 state == S_D3;
   endsequence

   a_desc_order: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_D0 |=> desc_walk)
      else $error("Descriptor words out of order.");

   a_bsw_done: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_D0 |=> ram_o.we && ram_o.data[15] && ram_o.addr == $past(stk))
      else $error("Block status word not written as finished.");

   a_tag_ext: assert property (@(posedge clk_i) disable iff (rst_i)
      res == `RES_EXT && tag_rise && !tt_set && !tt_clr && !tt_load
      |=> ttag == $past(ttag) + 16'h1)
      else $error("External tag edge did not advance the tag.");

   a_tag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !tt_inc && !tt_set && !tt_clr && !tt_load |=> $stable(ttag))
      else $error("Time tag moved without a tick.");

   a_tag_roll: assert property (@(posedge clk_i) disable iff (rst_i)
      tt_roll |=> ttag == 16'h0 && stat2[0])
      else $error("Tag wrap did not flag rollover.");

   a_sync_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      tt_clr && !tt_set |=> ttag == 16'h0)
      else $error("Synchronize did not clear the tag.");

   a_queue_pair: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_Q0 |=> state == S_Q1 ##1 qptr[5:0] == 6'($past(qptr[5:0], 2) + 6'h2))
      else $error("Queue pointer not past the written pair.");

   a_queue_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      q_wrap |=> qptr[5:0] == 6'h0 && stat2[4])
      else $error("Queue wrap not flagged.");

   a_vector_kind: assert property (@(posedge clk_i) disable iff (rst_i)
      state == S_Q0 |=> ram_o.we && ram_o.data[0] == $past(qmsg))
      else $error("Vector bit 0 does not match entry kind.");
endmodule

// *** rt_host_mem_model.sv ***
`timescale 1ns/100ps
module rt_host_mem_model
(
   input wire logic clk_i,
   input wire rt_log_pkg::ram_wr_t ram_i
);
   import rt_log_pkg::*;
   logic [15:0] mem [0:65535];
   // Shared RAM as the host sees it; every device write lands here.
   always @(posedge clk_i)
   begin
      if (ram_i.we === 1'b1)
      begin
         mem[ram_i.addr] <= ram_i.data;
      end
   end
endmodule

// *** rt_message_log_and_interrupt_queue_tb_top.sv ***
`timescale 1ns/100ps
`include "rt_log_map.svh"
module rt_message_log_and_interrupt_queue_tb_top;
   import rt_log_pkg::*;
   logic clk_i, rst_i, cyc, we, ack, irq, done, start, tag_clk, mpe, rpe, bdone;
   logic [6:0] adr;
   logic [31:0] wdat, rdat, q32;
   logic [15:0] paddr, stk, qp, tt, d;
   msg_info_t m, mi;
   ram_wr_t ram;
   int fails, samples_checked, cycles;
   rt_message_log_and_interrupt_queue i_rt_message_log_and_interrupt_queue (.clk_i(clk_i),
      .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .msg_start_i(start),
      .msg_done_i(done), .msg_i(mi), .tag_clk_i(tag_clk), .rtaddr_par_err_i(rpe),
      .ram_par_err_i(mpe), .ram_par_addr_i(paddr), .bit_done_i(bdone), .ram_o(ram),
      .irq_o(irq));
   rt_host_mem_model i_rt_host_mem_model (.clk_i(clk_i), .ram_i(ram));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         fails = fails + 1;
         give_verdict();
      end
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked = samples_checked + 1;
      if (exp !== got)
      begin
         fails = fails + 1;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wb(input logic [4:0] idx, input logic w, input logic [15:0] v);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {16'h0000, v};
      do @(posedge clk_i); while (ack !== 1'b1);
      q32 = rdat;
      cyc <= 1'b0;
   endtask
   task automatic send(input msg_info_t x);
      @(posedge clk_i);
      start <= 1'b1;
      @(posedge clk_i);
      start <= 1'b0;
      repeat (3) @(posedge clk_i);
      mi <= x;
      done <= 1'b1;
      @(posedge clk_i);
      done <= 1'b0;
      repeat (12) @(posedge clk_i);
   endtask
   function automatic msg_info_t rnd_msg();
      msg_info_t r;
      r = '0;
      r.cmd = 16'($urandom);
      r.data_ptr = 16'($urandom);
      r.mode_data = 16'($urandom);
      r.chan_b = 1'($urandom);
      r.illegal = 1'($urandom);
      r.err = 5'($urandom);
      return r;
   endfunction
   initial
   begin
      fails = 0;
      samples_checked = 0;
      rst_i = 1'b1;
      {cyc, we, done, start, tag_clk, mpe, rpe, bdone} = '0;
      adr = '0;
      wdat = '0;
      paddr = '0;
      mi = '0;
      void'($urandom(32'h3195428d));
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(`REG_QPTR, 1'b0, 16'h0000);
      check("qptr_reset", 32'h0, q32);
      wb(5'h1e, 1'b1, 16'hffff);
      wb(5'h1e, 1'b0, 16'h0000);
      check("unmapped", 32'h0, q32);
      stk = 16'h0100;
      qp = 16'h043c;
      tt = 16'($urandom);
      wb(`REG_MASK1, 1'b1, 16'h0001);
      wb(`REG_STACK, 1'b1, stk);
      wb(`REG_QPTR, 1'b1, qp);
      wb(`REG_TTAG, 1'b1, tt);
      for (int i = 0; i < 3; i++)
      begin
         m = rnd_msg();
         m.mode_code = (i == 2);
         wb(`REG_CFG, 1'b1, (i == 2) ? 16'h0046 : 16'h0006);
         send(m);
         check("stat", {16'h0, 1'b1, 1'b0, m.chan_b, m.illegal, 7'h00, m.err},
            i_rt_host_mem_model.mem[stk] & 16'hf01f);
         check("ttag", tt, i_rt_host_mem_model.mem[stk + 16'h1]);
         check("ptr", (i == 2) ? m.mode_data : m.data_ptr, i_rt_host_mem_model.mem[stk + 16'h2]);
         check("cmd", m.cmd, i_rt_host_mem_model.mem[stk + 16'h3]);
         check("vector", 16'h0003, i_rt_host_mem_model.mem[qp]);
         qp = {qp[15:6], qp[5:0] + 6'h01};
         check("param", stk, i_rt_host_mem_model.mem[qp]);
         qp = {qp[15:6], qp[5:0] + 6'h01};
         stk = stk + 16'h4;
      end
      wb(`REG_QPTR, 1'b0, 16'h0000);
      check("qptr_wrap", 32'h0402, q32);
      wb(`REG_STAT1, 1'b0, 16'h0000);
      check("stat1_eom", 32'h1, q32[0]);
      wb(`REG_STAT2, 1'b0, 16'h0000);
      check("q_roll", 32'h1, q32[4]);
      for (int j = 0; j < 3; j++)
      begin
         m = rnd_msg();
         m.illegal = 1'b0;
         m.err = (j == 0) ? 5'h00 : 5'h01;
         wb(`REG_CFG6, 1'b1, (j == 2) ? 16'h0100 : 16'h0080);
         send(m);
         if (j == 1)
            qp = qp + 16'h2;
         wb(`REG_QPTR, 1'b0, 16'h0000);
         check("filter", qp, q32);
      end
      wb(`REG_STAT1, 1'b1, 16'hffff);
      wb(`REG_STAT2, 1'b1, 16'hffff);
      wb(`REG_MASK2, 1'b1, 16'h0004);
      @(posedge clk_i);
      paddr <= 16'($urandom);
      mpe <= 1'b1;
      @(posedge clk_i);
      mpe <= 1'b0;
      repeat (12) @(posedge clk_i);
      check("nm_vector", 16'h0008, i_rt_host_mem_model.mem[qp]);
      check("nm_param", paddr, i_rt_host_mem_model.mem[qp + 16'h1]);
      check("irq_set", 32'h1, irq);
      wb(`REG_STAT2, 1'b1, 16'h0004);
      repeat (3) @(posedge clk_i);
      check("irq_clr", 32'h0, irq);
      wb(`REG_MASK2, 1'b1, 16'h000a);
      @(posedge clk_i);
      {rpe, bdone} <= 2'b11;
      @(posedge clk_i);
      {rpe, bdone} <= 2'b00;
      repeat (12) @(posedge clk_i);
      qp = qp + 16'h2;
      check("nm_multi_vec", 16'h0014, i_rt_host_mem_model.mem[qp]);
      check("nm_multi_par", 16'h0000, i_rt_host_mem_model.mem[qp + 16'h1]);
      qp = qp + 16'h2;
      wb(`REG_MASK2, 1'b1, 16'h0001);
      wb(`REG_CFG, 1'b1, 16'h0007);
      wb(`REG_TTAG, 1'b1, 16'hffff);
      repeat (2)
      begin
         @(posedge clk_i);
         tag_clk <= 1'b1;
         repeat (3) @(posedge clk_i);
         tag_clk <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      wb(`REG_TTAG, 1'b0, 16'h0000);
      check("ext_tag", 32'h1, q32);
      wb(`REG_STAT2, 1'b0, 16'h0000);
      check("tag_roll", 32'h1, q32[0]);
      check("roll_vec", 16'h0002, i_rt_host_mem_model.mem[qp]);
      check("roll_par", 16'h0000, i_rt_host_mem_model.mem[qp + 16'h1]);
      for (int k = 0; k < 3; k++)
      begin
         wb(`REG_CFG, 1'b1, 16'(k));
         wb(`REG_TTAG, 1'b1, 16'h0000);
         repeat ((400 << k) * 3) @(posedge clk_i);
         wb(`REG_TTAG, 1'b0, 16'h0000);
         check("tag_rate", 32'h3, q32);
      end
      wb(`REG_CFG, 1'b1, 16'h000e);
      wb(`REG_TTAG, 1'b1, 16'h1234);
      m = '0;
      m.sync_nodata = 1'b1;
      wb(`REG_STACK, 1'b1, 16'h017c);
      send(m);
      wb(`REG_TTAG, 1'b0, 16'h0000);
      check("sync_clr", 32'h0, q32);
      wb(`REG_STAT1, 1'b0, 16'h0000);
      check("stk_half", 32'h1, q32[6]);
      wb(`REG_CFG, 1'b1, 16'h0036);
      for (int n = 0; n < 2; n++)
      begin
         d = 16'($urandom);
         d[0] = (n == 0);
         m = '0;
         m.sync_data = 1'b1;
         m.mode_data = d;
         send(m);
         wb(`REG_TTAG, 1'b0, 16'h0000);
         check("sync_load", (n == 0) ? 16'h0000 : d, q32);
      end
      give_verdict();
   end
endmodule
